/* hw/timer_pkg.sv */
// Purpose: Shared constants and types for the cascadable 8-bit timers.
// Assumes: Byte-wide register port, one system clock.
// Notes: Channel index 0 is channel_zero, 1 channel_one, 2 channel_y,
// Notes: and 3 channel_x.
package timer_pkg;

	// ----------------------------------------------------------------
	// Channels and interrupt lines
	// ----------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam int CH_ZERO = 0;
	localparam int CH_ONE = 1;
	localparam int CH_Y = 2;
	localparam int CH_X = 3;
	localparam int IRQ_NUM = 13;
	localparam int IRQ_CAP_X = 9;
	localparam int IRQ_BASE_X = 10;

	// ----------------------------------------------------------------
	// Register map: addr[5] global, addr[4:3] channel, addr[2:0] reg
	// ----------------------------------------------------------------
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_STAT = 3'h1;
	localparam logic [2:0] REG_CMPA = 3'h2;
	localparam logic [2:0] REG_CMPB = 3'h3;
	localparam logic [2:0] REG_COUNT = 3'h4;
	localparam logic [5:0] OFS_CROSS = 6'h20;
	localparam logic [5:0] OFS_CAPCTL = 6'h21;
	localparam logic [5:0] OFS_CAPRISE = 6'h22;
	localparam logic [5:0] OFS_CAPFALL = 6'h23;

	// ----------------------------------------------------------------
	// Field codes and bit positions
	// ----------------------------------------------------------------
	localparam logic [2:0] CS_DIV2 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_CASCADE = 3'h4;
	localparam logic [2:0] CS_EXT_RISE = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_BOTH = 3'h7;
	localparam logic [1:0] CLR_MATCH_A = 2'h1;
	localparam logic [1:0] CLR_MATCH_B = 2'h2;
	localparam logic [1:0] CLR_EXT = 2'h3;
	localparam logic [1:0] OUT_LOW = 2'h1;
	localparam logic [1:0] OUT_HIGH = 2'h2;
	localparam logic [1:0] OUT_TOGGLE = 2'h3;
	localparam int CASC_X_BIT = 5;
	localparam int CASC_Y_BIT = 4;
	localparam int CAP_FLAG_BIT = 7;
	localparam int CAP_IEN_BIT = 6;
	localparam int CAP_START_BIT = 4;

	// ----------------------------------------------------------------
	// Reset values and the counter top value
	// ----------------------------------------------------------------
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [7:0] CMP_RST = 8'hFF;

	// Control byte: interrupt enables, clear select, clock select.
	typedef struct packed {
		logic [2:0] irq_en;
		logic [1:0] clear_sel;
		logic [2:0] clock_select_field;
	} channel_control_t;

	// Sticky events of one channel, in status bit order 7 to 5.
	typedef struct packed {
		logic match_a_flag;
		logic match_b_flag;
		logic wrap_flag;
	} chan_event_t;

endpackage

/* hw/dual_timer_pairs.sv */
// Purpose: Four 8-bit timer channels in two cascadable pairs.
// Assumes: All pins synchronous to clk_in; byte register port.
// Notes: Clear beats write, write beats count; flags keep set over clear.
//
// Contract
// - Pattern 0110 gives high on A, low on B.
// - Match signal fires at the next count tick.
// - Each match drives pin per output select.
// - Clear field zeroes counter on match A/B.
// - Rising external reset zeroes counter when selected.
// - Wrap flag sets on FF to 00.
// - Clock code 100 cascades channels zero and one.
// - Channel zero upper, channel one lower byte.
// - Zero flags on 16-bit match, one on low.
// - Zero's clear clears both; one's ignored.
// - Pins follow 16-bit and low-byte matches.
// - One counts zero's match A in match mode.
// - Pair Y/X cascades under cross-register select bits.
// - Y upper, X lower; flags per byte.
// - Y clear zeroes upper only; X clear active.
// - Y and X pins follow their byte matches.
// - X counts Y's match A in match mode.
// - Rise then fall copies X count to captures.
// - Capture clears start bit; rearm after reading zero.
// - Capture during capture read delays one cycle.
// - Start bit off disables capture, on selects pin.
// - Separate enabled request line per event.
// - Request lines ordered zero, one, Y, X.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
module dual_timer_pairs
	import timer_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [5:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic [NUM_CH-1:0] ext_clk_in,
	input wire logic [NUM_CH-1:0] ext_reset_pin_in,
	input wire logic capture_pin_x_in,
	output logic [NUM_CH-1:0] wave_out,
	output logic [IRQ_NUM-1:0] irq_out
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [7:0] cnt_q [NUM_CH]; // Counters.
	logic [7:0] cnt_d [NUM_CH]; // Next counter values.
	logic [7:0] cmpa_q [NUM_CH]; // Compare values A.
	logic [7:0] cmpb_q [NUM_CH]; // Compare values B.
	channel_control_t ctrl_q [NUM_CH]; // Control bytes.
	logic [3:0] osel_q [NUM_CH]; // Output select fields.
	chan_event_t flag_q [NUM_CH]; // Sticky flags.
	chan_event_t flag_d [NUM_CH]; // Next flags.
	logic [7:0] chan_rd [NUM_CH]; // Per-channel read byte.
	logic [NUM_CH-1:0] wave_q, wave_d; // Output pins.
	logic [NUM_CH-1:0] eclk_q, erst_q; // Pin history for edges.
	logic [5:0] presc_q; // Free prescaler.
	logic casc_x_q, casc_y_q; // Cross-pair select bits.
	logic cap_start_q, cap_ien_q, cap_flag_q; // Capture control.
	logic cap_seen_q; // Rising edge seen while armed.
	logic cap_pend_q; // Capture held back by a read.
	logic cap_pin_q; // Capture pin history.
	logic seen_zero_q; // Start bit was read as zero.
	logic [7:0] cap_rise_reg_q, cap_fall_reg_q; // Capture registers.
	logic [7:0] rdata_q; // Read data register.

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire glob = addr_in[5];
	wire [1:0] ch_sel = addr_in[4:3];
	wire [2:0] reg_sel = addr_in[2:0];
	wire wr_cross = wr_in && addr_in == OFS_CROSS;
	wire wr_capctl = wr_in && addr_in == OFS_CAPCTL;
	wire rd_capctl = rd_in && addr_in == OFS_CAPCTL;
	// A read of either capture register holds a capture back.
	wire capt_rd = rd_in && (addr_in == OFS_CAPRISE ||
		addr_in == OFS_CAPFALL);
	logic [NUM_CH-1:0] wr_ctrl, wr_stat, wr_cmpa, wr_cmpb, wr_cnt;

	// Event wires per channel.
	logic [NUM_CH-1:0] own_tick, tick, ma, mb, clr, clr_raw, wrap;
	logic [NUM_CH-1:0] eq_a, eq_b, ext_rise;
	logic [1:0] act [NUM_CH]; // Pin action after priority.

	// ----------------------------------------------------------------
	// Count clock selection
	// ----------------------------------------------------------------
	// Cascade and stop codes give no tick of their own; the pair logic
	// below supplies the cascade tick instead.
	function automatic logic sel_tick(input logic [2:0] cs,
		input logic [5:0] p, input logic now, input logic prev);
		case (cs)
			CS_DIV2: sel_tick = p[0];
			CS_DIV8: sel_tick = &p[2:0];
			CS_DIV64: sel_tick = &p[5:0];
			CS_EXT_RISE: sel_tick = now & ~prev;
			CS_EXT_FALL: sel_tick = ~now & prev;
			CS_EXT_BOTH: sel_tick = now ^ prev;
			default: sel_tick = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Pair modes
	// ----------------------------------------------------------------
	// Setting both modes of a pair stops its counters, so each mode
	// excludes the other; this also keeps the tick paths loop free.
	wire cs0_c = ctrl_q[CH_ZERO].clock_select_field == CS_CASCADE;
	wire cs1_c = ctrl_q[CH_ONE].clock_select_field == CS_CASCADE;
	wire csy_c = ctrl_q[CH_Y].clock_select_field == CS_CASCADE;
	wire csx_c = ctrl_q[CH_X].clock_select_field == CS_CASCADE;
	wire mode16_01 = cs0_c && !cs1_c;
	wire cmc_01 = cs1_c && !cs0_c;
	wire y16_sel = csy_c && casc_y_q;
	wire xcm_sel = csx_c && casc_x_q;
	wire mode16_yx = y16_sel && !xcm_sel;
	wire cmc_yx = xcm_sel && !y16_sel;

	// Upper bytes step on the lower byte's wrap tick.
	assign tick[CH_ZERO] = mode16_01 ?
		own_tick[CH_ONE] && cnt_q[CH_ONE] == COUNT_MAX :
		own_tick[CH_ZERO];
	assign tick[CH_ONE] = cmc_01 ?
		own_tick[CH_ZERO] && eq_a[CH_ZERO] : own_tick[CH_ONE];
	assign tick[CH_Y] = mode16_yx ?
		own_tick[CH_X] && cnt_q[CH_X] == COUNT_MAX : own_tick[CH_Y];
	assign tick[CH_X] = cmc_yx ?
		own_tick[CH_Y] && eq_a[CH_Y] : own_tick[CH_X];

	// A match is signalled at the tick that leaves the matching value.
	// Channel zero in 16-bit mode needs both bytes equal.
	assign ma[CH_ZERO] = mode16_01 ?
		own_tick[CH_ONE] && eq_a[CH_ZERO] && eq_a[CH_ONE] :
		tick[CH_ZERO] && eq_a[CH_ZERO];
	assign mb[CH_ZERO] = mode16_01 ?
		own_tick[CH_ONE] && eq_b[CH_ZERO] && eq_b[CH_ONE] :
		tick[CH_ZERO] && eq_b[CH_ZERO];

	// Channel one's clear is replaced by channel zero's in 16-bit mode.
	// Pair Y/X keeps separate clears, so Y zeroes only its byte.
	assign clr[CH_ZERO] = clr_raw[CH_ZERO];
	assign clr[CH_ONE] = mode16_01 ? clr_raw[CH_ZERO] :
		clr_raw[CH_ONE];
	assign clr[CH_Y] = clr_raw[CH_Y];
	assign clr[CH_X] = clr_raw[CH_X];

	// ----------------------------------------------------------------
	// Per-channel logic
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		localparam int IB = (i == CH_X) ? IRQ_BASE_X : 3 * i;
		logic [1:0] act_a, act_b;
		wire chan_hit = !glob && ch_sel == 2'(i);

		assign wr_ctrl[i] = wr_in && chan_hit && reg_sel == REG_CTRL;
		assign wr_stat[i] = wr_in && chan_hit && reg_sel == REG_STAT;
		assign wr_cmpa[i] = wr_in && chan_hit && reg_sel == REG_CMPA;
		assign wr_cmpb[i] = wr_in && chan_hit && reg_sel == REG_CMPB;
		assign wr_cnt[i] = wr_in && chan_hit && reg_sel == REG_COUNT;

		assign own_tick[i] = sel_tick(ctrl_q[i].clock_select_field,
			presc_q, ext_clk_in[i], eclk_q[i]);
		assign ext_rise[i] = ext_reset_pin_in[i] && !erst_q[i];
		assign eq_a[i] = cnt_q[i] == cmpa_q[i];
		assign eq_b[i] = cnt_q[i] == cmpb_q[i];
		if (i != CH_ZERO) begin : g_match
			assign ma[i] = tick[i] && eq_a[i];
			assign mb[i] = tick[i] && eq_b[i];
		end

		// Clear source chosen by the clear field.
		assign clr_raw[i] =
			(ctrl_q[i].clear_sel == CLR_MATCH_A && ma[i]) ||
			(ctrl_q[i].clear_sel == CLR_MATCH_B && mb[i]) ||
			(ctrl_q[i].clear_sel == CLR_EXT && ext_rise[i]);
		assign wrap[i] = tick[i] && cnt_q[i] == COUNT_MAX &&
			!clr[i];

		// Clear wins over a write, a write wins over a count.
		assign cnt_d[i] = clr[i] ? COUNT_RST :
			wr_cnt[i] ? wdata_in :
			tick[i] ? cnt_q[i] + 8'h01 : cnt_q[i];

		// Writing 0 clears a flag; a new event in that cycle wins.
		assign flag_d[i] = chan_event_t'({ma[i], mb[i], wrap[i]} |
			(flag_q[i] & ~(wr_stat[i] ? ~wdata_in[7:5] : 3'h0)));

		// When both matches hit, toggle beats high beats low beats
		// keep, which is exactly the numeric order of the codes.
		assign act_a = ma[i] ? osel_q[i][1:0] : 2'h0;
		assign act_b = mb[i] ? osel_q[i][3:2] : 2'h0;
		assign act[i] = (act_a > act_b) ? act_a : act_b;
		assign wave_d[i] = (act[i] == OUT_TOGGLE) ? ~wave_q[i] :
			(act[i] == OUT_HIGH) ? 1'b1 :
			(act[i] == OUT_LOW) ? 1'b0 : wave_q[i];

		// Each event has its own enabled request line.
		assign irq_out[IB] = flag_q[i].match_a_flag &&
			ctrl_q[i].irq_en[2];
		assign irq_out[IB+1] = flag_q[i].match_b_flag &&
			ctrl_q[i].irq_en[1];
		assign irq_out[IB+2] = flag_q[i].wrap_flag &&
			ctrl_q[i].irq_en[0];

		assign chan_rd[i] = (reg_sel == REG_CTRL) ? {ctrl_q[i]} :
			(reg_sel == REG_STAT) ? {flag_q[i], 1'b0, osel_q[i]} :
			(reg_sel == REG_CMPA) ? cmpa_q[i] :
			(reg_sel == REG_CMPB) ? cmpb_q[i] :
			(reg_sel == REG_COUNT) ? cnt_q[i] : 8'h00;

		// Channel state; control bytes load straight from the bus.
		always_ff @(posedge clk_in) begin
			if (srst_in) begin
				cnt_q[i] <= COUNT_RST;
				cmpa_q[i] <= CMP_RST;
				cmpb_q[i] <= CMP_RST;
				ctrl_q[i] <= '0;
				osel_q[i] <= 4'h0;
				flag_q[i] <= '0;
				wave_q[i] <= 1'b0;
			end else begin
				cnt_q[i] <= cnt_d[i];
				flag_q[i] <= flag_d[i];
				wave_q[i] <= wave_d[i];
				if (wr_cmpa[i]) begin
					cmpa_q[i] <= wdata_in;
				end
				if (wr_cmpb[i]) begin
					cmpb_q[i] <= wdata_in;
				end
				if (wr_ctrl[i]) begin
					ctrl_q[i] <= channel_control_t'(wdata_in);
				end
				if (wr_stat[i]) begin
					osel_q[i] <= wdata_in[3:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Input capture on channel X
	// ----------------------------------------------------------------
	wire cap_rise = capture_pin_x_in && !cap_pin_q;
	wire cap_fall = !capture_pin_x_in && cap_pin_q;
	// Only an armed start bit routes the pin to the capture logic.
	wire cap_event = cap_start_q && cap_seen_q && cap_fall;
	// A capture that meets a capture read lands one cycle later.
	wire cap_fire = cap_pend_q || (cap_event && !capt_rd);
	wire cap_pend_d = cap_event && capt_rd;
	wire cap_seen_d = cap_start_q && !cap_event &&
		(cap_seen_q || cap_rise);
	// Re-arming only after the bit was seen as zero.
	wire cap_start_d = cap_fire ? 1'b0 :
		(wr_capctl && !wdata_in[CAP_START_BIT]) ? 1'b0 :
		(wr_capctl && seen_zero_q) ? 1'b1 : cap_start_q;
	wire seen_zero_d = wr_capctl ? 1'b0 :
		(rd_capctl && !cap_start_q) ? 1'b1 : seen_zero_q;
	wire cap_flag_d = cap_fire || (cap_flag_q &&
		!(wr_capctl && !wdata_in[CAP_FLAG_BIT]));
	assign irq_out[IRQ_CAP_X] = cap_flag_q && cap_ien_q;

	// Capture and cross-pair state.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cap_start_q <= 1'b0;
			cap_ien_q <= 1'b0;
			cap_flag_q <= 1'b0;
			cap_seen_q <= 1'b0;
			cap_pend_q <= 1'b0;
			seen_zero_q <= 1'b0;
			cap_rise_reg_q <= COUNT_RST;
			cap_fall_reg_q <= COUNT_RST;
			casc_x_q <= 1'b0;
			casc_y_q <= 1'b0;
		end else begin
			cap_start_q <= cap_start_d;
			cap_flag_q <= cap_flag_d;
			cap_seen_q <= cap_seen_d;
			cap_pend_q <= cap_pend_d;
			seen_zero_q <= seen_zero_d;
			if (cap_fire) begin
				cap_rise_reg_q <= cnt_q[CH_X];
				cap_fall_reg_q <= cnt_q[CH_X];
			end
			if (wr_capctl) begin
				cap_ien_q <= wdata_in[CAP_IEN_BIT];
			end
			if (wr_cross) begin
				casc_x_q <= wdata_in[CASC_X_BIT];
				casc_y_q <= wdata_in[CASC_Y_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin history, prescaler and read port
	// ----------------------------------------------------------------
	wire [7:0] glob_rd = (addr_in == OFS_CROSS) ?
		{2'h0, casc_x_q, casc_y_q, 4'h0} :
		(addr_in == OFS_CAPCTL) ?
		{cap_flag_q, cap_ien_q, 1'b0, cap_start_q, 4'h0} :
		(addr_in == OFS_CAPRISE) ? cap_rise_reg_q :
		(addr_in == OFS_CAPFALL) ? cap_fall_reg_q : 8'h00;
	wire [7:0] rd_mux = glob ? glob_rd : chan_rd[ch_sel];

	// Read data stand for one cycle per strobe cycle, zero otherwise.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			presc_q <= 6'h00;
			eclk_q <= '0;
			erst_q <= '0;
			cap_pin_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			presc_q <= presc_q + 6'h01;
			eclk_q <= ext_clk_in;
			erst_q <= ext_reset_pin_in;
			cap_pin_q <= capture_pin_x_in;
			rdata_q <= rd_in ? rd_mux : 8'h00;
		end
	end

	assign rdata_out = rdata_q;
	assign wave_out = wave_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	property p_pulse_high;
		osel_q[CH_ZERO] == 4'h6 && ma[CH_ZERO] && !mb[CH_ZERO] |=>
			wave_q[CH_ZERO];
	endproperty
	a_pulse_high: assert property (p_pulse_high)
		else $error("Pulse output did not rise on match A.");

	property p_flag_late;
		$rose(flag_q[CH_X].match_a_flag) |->
			$past(tick[CH_X]) && $past(eq_a[CH_X]);
	endproperty
	a_flag_late: assert property (p_flag_late)
		else $error("Match flag set without a count tick.");

	property p_toggle;
		ma[CH_ZERO] && !mb[CH_ZERO] &&
			osel_q[CH_ZERO][1:0] == OUT_TOGGLE |=>
			wave_q[CH_ZERO] != $past(wave_q[CH_ZERO]);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("Toggle output did not change.");

	property p_clear_a;
		ctrl_q[CH_ZERO].clear_sel == CLR_MATCH_A && ma[CH_ZERO] |=>
			cnt_q[CH_ZERO] == COUNT_RST;
	endproperty
	a_clear_a: assert property (p_clear_a)
		else $error("Counter not cleared on match A.");

	property p_ext_clear16;
		mode16_01 && ctrl_q[CH_ZERO].clear_sel == CLR_EXT &&
			ext_rise[CH_ZERO] |=> cnt_q[CH_ZERO] == COUNT_RST &&
			cnt_q[CH_ONE] == COUNT_RST;
	endproperty
	a_ext_clear16: assert property (p_ext_clear16)
		else $error("External reset left part of the counter.");

	property p_wrap;
		tick[CH_ONE] && cnt_q[CH_ONE] == COUNT_MAX && !clr[CH_ONE] &&
			!wr_cnt[CH_ONE] |=>
			flag_q[CH_ONE].wrap_flag && cnt_q[CH_ONE] == COUNT_RST;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("Wrap flag missing after FF.");

	property p_carry16;
		mode16_01 && own_tick[CH_ONE] && cnt_q[CH_ONE] == COUNT_MAX &&
			!clr[CH_ZERO] && !wr_cnt[CH_ZERO] |=>
			cnt_q[CH_ZERO] == $past(cnt_q[CH_ZERO]) + 8'h01;
	endproperty
	a_carry16: assert property (p_carry16)
		else $error("Upper byte missed the carry.");

	property p_cmc_count;
		cmc_01 && ma[CH_ZERO] && !clr[CH_ONE] && !wr_cnt[CH_ONE] |=>
			cnt_q[CH_ONE] == $past(cnt_q[CH_ONE]) + 8'h01;
	endproperty
	a_cmc_count: assert property (p_cmc_count)
		else $error("Channel one missed a match A count.");

	property p_capture;
		cap_fire |=> cap_rise_reg_q == $past(cnt_q[CH_X]) &&
			cap_fall_reg_q == $past(cnt_q[CH_X]) && !cap_start_q;
	endproperty
	a_capture: assert property (p_capture)
		else $error("Capture registers not loaded.");

	property p_cap_delay;
		cap_event && capt_rd |-> !cap_fire ##1 cap_fire;
	endproperty
	a_cap_delay: assert property (p_cap_delay)
		else $error("Capture during read not delayed by one.");

endmodule

/* verif/timer_pin_model.sv */
// Purpose: Far-side pin model for the timer block: count clocks,
// Purpose: counter reset pins and the channel X capture pin.
// Assumes: Called from the bench right after a rising clock edge.
// Notes: Levels are held whole cycles, so minimum widths round up.
`timescale 1ns/100ps
module timer_pin_model (
	input wire logic clk_in,
	output logic [3:0] ext_clk_out,
	output logic [3:0] ext_reset_out,
	output logic capture_out
);

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------

	// All pins rest low until a task pulses them.
	initial begin
		ext_clk_out = 4'h0;
		ext_reset_out = 4'h0;
		capture_out = 1'b0;
	end

	// Waits n system clock edges with the pins unchanged.
	task hold(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	// One count-clock period on channel ch; three cycles a level keeps
	// clear of both the single-edge and the both-edge minimum.
	task tick(input int ch);
		ext_clk_out[ch] <= 1'b1;
		hold(3);
		ext_clk_out[ch] <= 1'b0;
		hold(3);
	endtask

	// A clearing pulse three cycles wide on channel ch.
	task clr_pulse(input int ch);
		ext_reset_out[ch] <= 1'b1;
		hold(3);
		ext_reset_out[ch] <= 1'b0;
		hold(3);
	endtask

	// A rising then a falling edge on the capture pin.
	task cap_pulse();
		capture_out <= 1'b1;
		hold(4);
		capture_out <= 1'b0;
		hold(4);
	endtask

endmodule

/* verif/test_dual_timer_pairs.sv */
// Purpose: Self-checking bench for the four cascadable timer channels.
// Assumes: Register port with read data one cycle after the strobe.
// Notes: Six scenarios start from a fresh reset; the other four continue from the one before.
`timescale 1ns/100ps
module test_dual_timer_pairs import timer_pkg::*;;

	// ----------------------------------------------------------------
	// Stimulus signals and instances
	// ----------------------------------------------------------------
	logic clk_in = 1'b0; // System clock, 8 ns period.
	logic srst_in = 1'b1; // Synchronous reset, held at start.
	logic [5:0] addr_in = 6'h00; // Register address.
	logic [7:0] wdata_in = 8'h00; // Write data.
	logic wr_in = 1'b0; // Write strobe.
	logic rd_in = 1'b0; // Read strobe.
	logic [7:0] rdata_out; // Read data from the block.
	logic [3:0] ext_clk; // Count clock pins from the model.
	logic [3:0] ext_rst; // Counter reset pins from the model.
	logic cap; // Capture pin from the model.
	logic [3:0] wave; // Compare output pins.
	logic [IRQ_NUM-1:0] irq; // Request lines.
	logic [7:0] v; // Scratch read value.
	int err_count = 0; // Mismatches seen.
	int checks_done = 0; // Comparisons made.

	always #4 clk_in = ~clk_in;

	dual_timer_pairs uut (
		.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .ext_clk_in(ext_clk),
		.ext_reset_pin_in(ext_rst), .capture_pin_x_in(cap),
		.wave_out(wave), .irq_out(irq)
	);

	timer_pin_model pins (
		.clk_in(clk_in), .ext_clk_out(ext_clk),
		.ext_reset_out(ext_rst), .capture_out(cap)
	);

	// ----------------------------------------------------------------
	// Bus tasks and comparison
	// ----------------------------------------------------------------

	// Channel register address: channel in [4:3], register in [2:0].
	function automatic logic [5:0] ra(input int ch, input logic [2:0] r);
		return {1'b0, ch[1:0], r};
	endfunction

	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One-cycle write; a gap cycle follows so strobes never merge.
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		@(posedge clk_in);
	endtask

	// One-cycle read; data is taken in the single cycle it stands.
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
		@(posedge clk_in);
	endtask

	// Reads a register and compares it with the expected byte.
	task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk($sformatf("reg %h", a), d, exp);
	endtask

	// Reset held for four cycles, released one edge before traffic.
	task automatic do_reset();
		srst_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		srst_in <= 1'b0;
		@(posedge clk_in);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog: the scenarios need a few hundred cycles at most.
	initial begin
		repeat (20000) @(posedge clk_in);
		err_count++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		do_reset();
		// Reset values and an unmapped place that must read zero.
		rchk(ra(CH_ZERO, REG_CMPA), 8'hFF);
		rchk(ra(CH_X, REG_COUNT), 8'h00);
		rchk(6'h2F, 8'h00);
		// Duty pulse: high on match A with clear, low on match B.
		wr(ra(CH_ZERO, REG_CMPA), 8'h03);
		wr(ra(CH_ZERO, REG_CMPB), 8'h01);
		wr(ra(CH_ZERO, REG_STAT), 8'h06);
		wr(ra(CH_ZERO, REG_CTRL), {3'h4, CLR_MATCH_A, CS_EXT_RISE});
		repeat (3) pins.tick(CH_ZERO);
		rchk(ra(CH_ZERO, REG_COUNT), 8'h03);
		rchk(ra(CH_ZERO, REG_STAT), 8'h46);
		pins.tick(CH_ZERO);
		rchk(ra(CH_ZERO, REG_COUNT), 8'h00);
		rchk(ra(CH_ZERO, REG_STAT), 8'hC6);
		chk("wave0", {7'h0, wave[0]}, 8'h01);
		chk("irq", {3'h0, irq[4:0]}, 8'h01);
		repeat (2) pins.tick(CH_ZERO);
		chk("wave0", {7'h0, wave[0]}, 8'h00);
		// Wrap on channel one; compares at FF also match on the way.
		do_reset();
		wr(ra(CH_ONE, REG_COUNT), 8'hFE);
		wr(ra(CH_ONE, REG_CTRL), {3'h1, 2'h0, CS_EXT_RISE});
		repeat (2) pins.tick(CH_ONE);
		rchk(ra(CH_ONE, REG_STAT), 8'hE0);
		chk("irq", irq[7:0], 8'h20);
		// External reset clears only where it is selected.
		wr(ra(CH_Y, REG_COUNT), 8'h40);
		wr(ra(CH_X, REG_COUNT), 8'h40);
		wr(ra(CH_Y, REG_CTRL), {3'h0, CLR_EXT, CS_EXT_RISE});
		pins.clr_pulse(CH_Y);
		pins.clr_pulse(CH_X);
		rchk(ra(CH_Y, REG_COUNT), 8'h00);
		rchk(ra(CH_X, REG_COUNT), 8'h40);
		// Pair zero/one as one 16-bit counter; low byte clear ignored.
		do_reset();
		wr(ra(CH_ONE, REG_COUNT), 8'hFF);
		wr(ra(CH_ZERO, REG_CMPA), 8'h01);
		wr(ra(CH_ONE, REG_CMPA), 8'h00);
		wr(ra(CH_ZERO, REG_STAT), 8'h02);
		wr(ra(CH_ONE, REG_CTRL), {3'h0, CLR_MATCH_B, CS_EXT_RISE});
		wr(ra(CH_ZERO, REG_CTRL), {3'h0, CLR_MATCH_A, CS_CASCADE});
		pins.tick(CH_ONE);
		rchk(ra(CH_ZERO, REG_COUNT), 8'h01);
		rchk(ra(CH_ONE, REG_COUNT), 8'h00);
		rchk(ra(CH_ZERO, REG_STAT), 8'h02);
		pins.tick(CH_ONE);
		rchk(ra(CH_ZERO, REG_COUNT), 8'h00);
		rchk(ra(CH_ZERO, REG_STAT), 8'h82);
		rd(ra(CH_ONE, REG_STAT), v);
		chk("ch1 flags", v, 8'hE0);
		chk("wave0", {7'h0, wave[0]}, 8'h01);
		// The zero pin must clear both bytes of the 16-bit count.
		wr(ra(CH_ZERO, REG_CTRL), {3'h0, CLR_EXT, CS_CASCADE});
		pins.tick(CH_ONE);
		pins.clr_pulse(CH_ZERO);
		rchk(ra(CH_ONE, REG_COUNT), 8'h00);
		// Channel one counts match A of channel zero; pin toggles.
		do_reset();
		wr(ra(CH_ZERO, REG_CMPA), 8'h01);
		wr(ra(CH_ZERO, REG_STAT), 8'h03);
		wr(ra(CH_ZERO, REG_CTRL), {3'h0, CLR_MATCH_A, CS_EXT_RISE});
		wr(ra(CH_ONE, REG_CTRL), {3'h0, 2'h0, CS_CASCADE});
		repeat (2) pins.tick(CH_ZERO);
		rchk(ra(CH_ONE, REG_COUNT), 8'h01);
		chk("wave0", {7'h0, wave[0]}, 8'h01);
		repeat (2) pins.tick(CH_ZERO);
		rchk(ra(CH_ONE, REG_COUNT), 8'h02);
		chk("wave0", {7'h0, wave[0]}, 8'h00);
		// Pair Y/X as 16 bits; Y reset pin clears the upper byte only.
		do_reset();
		wr(OFS_CROSS, 8'h10);
		wr(ra(CH_X, REG_COUNT), 8'hFF);
		wr(ra(CH_Y, REG_CTRL), {3'h0, CLR_EXT, CS_CASCADE});
		wr(ra(CH_X, REG_CTRL), {3'h0, 2'h0, CS_EXT_RISE});
		repeat (2) pins.tick(CH_X);
		rchk(ra(CH_Y, REG_COUNT), 8'h01);
		pins.clr_pulse(CH_Y);
		rchk(ra(CH_Y, REG_COUNT), 8'h00);
		rchk(ra(CH_X, REG_COUNT), 8'h01);
		// Capture: ignored while off, then taken once when armed.
		do_reset();
		wr(ra(CH_X, REG_CTRL), {3'h0, 2'h0, CS_EXT_RISE});
		repeat (3) pins.tick(CH_X);
		pins.cap_pulse();
		rchk(OFS_CAPFALL, 8'h00);
		rchk(OFS_CAPCTL, 8'h00);
		wr(OFS_CAPCTL, 8'h50);
		pins.cap_pulse();
		rchk(OFS_CAPRISE, 8'h03);
		rchk(OFS_CAPFALL, 8'h03);
		rchk(OFS_CAPCTL, 8'hC0);
		chk("irq cap", {7'h0, irq[IRQ_CAP_X]}, 8'h01);
		// A falling edge that meets a capture read lands one cycle late.
		wr(OFS_CAPCTL, 8'h50);
		pins.tick(CH_X);
		fork
			pins.cap_pulse();
			begin
				repeat (4) @(posedge clk_in);
				rchk(OFS_CAPRISE, 8'h03);
			end
		join
		rchk(OFS_CAPFALL, 8'h04);
		wrap_up();
	end

endmodule
